// [verilog/rbm_defines.vh]
// Constants for the reset sequencer and boot-mode strap latch.
// Assumes a single 10 MHz system clock and an active-high asynchronous reset.
//
// Summary of operation
// - Brown-out on either supply holds internal reset.
// - Supply droop while running shuts amplifier down.
// - One external reset input, active low.
// - External reset clears all state except test; boot_code and the registered boot selection outputs keep their values.
// - In reset: resets active, oscillator on, PLL off.
// - Latch boot mode at reset release, then boot.
// - Boot mode from four straps, D down to A.
// - Unassigned strap codes are reserved, no source.
// - 0000 I2C slave at 88; 0011 SPI slave.
// - 0010 SPI master, copy of 0001.
// - 0111 fast async serial slave, 384 kb/s.
// - 1011 async serial slave at 9600 b/s.
// - 1100 HDA combo master; 1101 copy; 1110 HDA.
// - 1111 failsafe two-wire ROM on general pins.
// - Encrypted and plain images from any source.
// - Valid loaded image runs directly, else multi-step.
// - Counter delays internal reset release after deassert.
// - PLL bypassed until configured and locked.
`ifndef RBM_DEFINES_VH
`define RBM_DEFINES_VH

// ****************************************************************
// Timing.
// ****************************************************************
`define RBM_CLK_HZ 10000000
`define RBM_REL_TIME_US 100
`define RBM_REL_CYCLES ((`RBM_REL_TIME_US * `RBM_CLK_HZ + 999999) / 1000000)
`define RBM_CNT_W 11

// ****************************************************************
// Strap codes.
// ****************************************************************
`define RBM_CODE_I2C_SLAVE 4'h0
`define RBM_CODE_COMBO 4'h1
`define RBM_CODE_SPI_MASTER 4'h2
`define RBM_CODE_SPI_SLAVE 4'h3
`define RBM_CODE_FAST_SER 4'h7
`define RBM_CODE_SLOW_SER 4'hb
`define RBM_CODE_HDA_COMBO 4'hc
`define RBM_CODE_HDA_COPY 4'hd
`define RBM_CODE_HDA_BOOT 4'he
`define RBM_CODE_FAILSAFE 4'hf

// ****************************************************************
// Boot source one-hot positions.
// ****************************************************************
`define RBM_SRC_W 8
`define RBM_SRC_I2C_SLV 0
`define RBM_SRC_I2C_ROM 1
`define RBM_SRC_SPI_ROM 2
`define RBM_SRC_SPI_SLV 3
`define RBM_SRC_SER 4
`define RBM_SRC_HDA 5
`define RBM_SRC_GPIN 6
`define RBM_SRC_MASTER 7

// ****************************************************************
// Interface rates in bits per second.
// ****************************************************************
`define RBM_RATE_W 24
`define RBM_RATE_EXT 24'h000000
`define RBM_RATE_400K 24'h061a80
`define RBM_RATE_1M53 24'h17587d
`define RBM_RATE_384K 24'h05dc00
`define RBM_RATE_9600 24'h002580
`define RBM_I2C_SLV_ADDR 7'h58

`endif

// [verilog/rbm_mode_decode.v]
// Combinational decode of a four-bit strap code into a boot source set.
// Assumes the caller registers the outputs.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module rbm_mode_decode (
  // Strap code, bit 3 is strap D.
  input wire [3:0] code,
  // Decoded selection.
  output reg [`RBM_SRC_W-1:0] src,
  output reg [`RBM_RATE_W-1:0] rate,
  output reg valid
);

  // ****************************************************************
  // Code table.
  // ****************************************************************

  // Each assigned code maps to its sources and rate; others stay empty.
  always @* begin
    src = {`RBM_SRC_W{1'b0}};
    rate = `RBM_RATE_EXT;
    valid = 1'b1;
    case (code)
      `RBM_CODE_I2C_SLAVE: begin
        src[`RBM_SRC_I2C_SLV] = 1'b1;
      end
      `RBM_CODE_SPI_SLAVE: begin
        src[`RBM_SRC_SPI_SLV] = 1'b1;
      end
      `RBM_CODE_COMBO: begin
        src[`RBM_SRC_I2C_ROM] = 1'b1;
        src[`RBM_SRC_SPI_ROM] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
        rate = `RBM_RATE_400K;
      end
      `RBM_CODE_SPI_MASTER: begin
        // Pin-compatible copy of combo mode at the faster SPI rate.
        src[`RBM_SRC_I2C_ROM] = 1'b1;
        src[`RBM_SRC_SPI_ROM] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
        rate = `RBM_RATE_1M53;
      end
      `RBM_CODE_FAST_SER: begin
        src[`RBM_SRC_SER] = 1'b1;
        rate = `RBM_RATE_384K;
      end
      `RBM_CODE_SLOW_SER: begin
        src[`RBM_SRC_SER] = 1'b1;
        rate = `RBM_RATE_9600;
      end
      `RBM_CODE_HDA_COMBO: begin
        src[`RBM_SRC_HDA] = 1'b1;
        src[`RBM_SRC_SPI_ROM] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
        rate = `RBM_RATE_1M53;
      end
      `RBM_CODE_HDA_COPY: begin
        src[`RBM_SRC_HDA] = 1'b1;
        src[`RBM_SRC_SPI_ROM] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
        rate = `RBM_RATE_400K;
      end
      `RBM_CODE_HDA_BOOT: begin
        src[`RBM_SRC_HDA] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
      end
      `RBM_CODE_FAILSAFE: begin
        src[`RBM_SRC_GPIN] = 1'b1;
        src[`RBM_SRC_MASTER] = 1'b1;
        rate = `RBM_RATE_400K;
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end

endmodule

// [verilog/rbm_rel_counter.v]
// Release counter that stretches reset past the external deassertion.
// Assumes restart is a clean synchronous level.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module rbm_rel_counter (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Restart while high.
  input wire restart,
  // High once the count has elapsed.
  output reg done
);

  // ****************************************************************
  // Counter.
  // ****************************************************************

  reg [`RBM_CNT_W-1:0] cnt_r; // Cycles since restart fell.

  // Counts up after restart falls; done rises at the full count.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {`RBM_CNT_W{1'b0}};
      done <= 1'b0;
    end else if (restart) begin
      cnt_r <= {`RBM_CNT_W{1'b0}};
      done <= 1'b0;
    end else if (cnt_r == `RBM_REL_CYCLES - 1) begin
      done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(`RBM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [verilog/rbm_boot_ctrl.v]
// Top of the reset sequencer and boot-mode strap latch.
// Assumes all inputs are synchronous to sys_clk and straps are board ties.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module rbm_boot_ctrl (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // External reset and supply monitors.
  input wire ext_reset_low,
  input wire bod_core_ok,
  input wire bod_io_ok,
  // Boot straps.
  input wire boot_strap_3,
  input wire boot_strap_2,
  input wire boot_strap_1,
  input wire boot_strap_0,
  // Status from firmware side.
  input wire pll_locked,
  input wire pll_cfg_done,
  input wire image_valid,
  input wire image_loaded,
  input wire image_encrypted,
  // Reset and clock control.
  output reg sys_reset,
  output reg osc_enable,
  output reg pll_enable,
  output reg pll_bypass,
  output reg amp_shutdown,
  // Boot selection.
  output reg [3:0] boot_code,
  output reg [`RBM_SRC_W-1:0] boot_src,
  output reg [`RBM_RATE_W-1:0] boot_rate,
  output reg boot_reserved,
  output reg boot_start,
  output reg [6:0] i2c_slave_addr,
  output reg gen_pin_one_is_clk,
  output reg gen_pin_zero_is_data,
  output reg async_serial_if_en,
  // Boot outcome.
  output reg decrypt_en,
  output reg direct_run,
  output reg multi_step
);

  // ****************************************************************
  // States.
  // ****************************************************************

  localparam ST_HOLD = 2'h0; // In reset.
  localparam ST_WAIT = 2'h1; // Release counter running.
  localparam ST_BOOT = 2'h2; // Boot loading.
  localparam ST_RUN = 2'h3; // Application running.

  // ****************************************************************
  // Signals.
  // ****************************************************************

  reg [1:0] state_r; // Sequencer state.
  reg [1:0] state_nxt; // Next sequencer state.
  wire supplies_ok; // Both supplies above threshold.
  wire hold_req; // Any reset source active.
  wire cnt_done; // Release count elapsed.
  wire [3:0] strap_now; // Live strap pins.
  wire [`RBM_SRC_W-1:0] dec_src; // Decoded sources.
  wire [`RBM_RATE_W-1:0] dec_rate; // Decoded rate.
  wire dec_valid; // Code assigned.

  assign supplies_ok = bod_core_ok & bod_io_ok;
  assign hold_req = ~ext_reset_low | ~supplies_ok;
  assign strap_now = {boot_strap_3, boot_strap_2, boot_strap_1, boot_strap_0};

  // ****************************************************************
  // Submodules.
  // ****************************************************************

  // Counter restarts whenever any reset source is active.
  rbm_rel_counter u_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(hold_req),
    .done(cnt_done)
  );

  // Decoder works on the latched code so the outputs stay stable.
  rbm_mode_decode u_dec (
    .code(boot_code),
    .src(dec_src),
    .rate(dec_rate),
    .valid(dec_valid)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************

  // Any reset source drops back to hold from any state.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (!hold_req) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end else if (cnt_done) begin
          state_nxt = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end else if (image_loaded) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hold_req) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer register and reset controls.
  // ****************************************************************

  // Internal reset stays active through hold and the release wait.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_HOLD;
      sys_reset <= 1'b1;
      osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      pll_bypass <= 1'b1;
      amp_shutdown <= 1'b1;
    end else begin
      state_r <= state_nxt;
      // The oscillator never stops, even in reset.
      osc_enable <= 1'b1;
      sys_reset <= (state_nxt == ST_HOLD) || (state_nxt == ST_WAIT);
      pll_enable <= !((state_nxt == ST_HOLD) || (state_nxt == ST_WAIT));
      // The system runs from the crystal until the PLL is set up and locked.
      pll_bypass <= (state_nxt != ST_RUN) || !(pll_cfg_done && pll_locked);
      // A droop sets amp_shutdown on the next clock edge, together with the state update.
      amp_shutdown <= !supplies_ok || (state_nxt != ST_RUN);
    end
  end

  // ****************************************************************
  // Strap latch.
  // ****************************************************************

  // Captured only on the cycle hold ends with every reset source released, which
  // keeps the code stable against later strap motion.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_code <= 4'h0;
    end else if (state_r == ST_HOLD && !hold_req) begin
      boot_code <= strap_now;
    end
  end

  // ****************************************************************
  // Boot outputs.
  // ****************************************************************

  // Decoded selection is registered; boot_start pulses on boot entry.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_src <= {`RBM_SRC_W{1'b0}};
      boot_rate <= `RBM_RATE_EXT;
      boot_reserved <= 1'b0;
      boot_start <= 1'b0;
      i2c_slave_addr <= 7'h00;
      gen_pin_one_is_clk <= 1'b0;
      gen_pin_zero_is_data <= 1'b0;
      async_serial_if_en <= 1'b0;
    end else begin
      boot_src <= dec_src;
      boot_rate <= dec_rate;
      boot_reserved <= !dec_valid;
      // No boot starts from a reserved code.
      boot_start <= (state_r == ST_WAIT) && (state_nxt == ST_BOOT) && dec_valid;
      i2c_slave_addr <= dec_src[`RBM_SRC_I2C_SLV] ? `RBM_I2C_SLV_ADDR : 7'h00;
      gen_pin_one_is_clk <= dec_src[`RBM_SRC_GPIN];
      gen_pin_zero_is_data <= dec_src[`RBM_SRC_GPIN];
      async_serial_if_en <= dec_src[`RBM_SRC_SER];
    end
  end

  // ****************************************************************
  // Image outcome.
  // ****************************************************************

  // Any source may carry either image form, so decryption follows the image.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      decrypt_en <= 1'b0;
      direct_run <= 1'b0;
      multi_step <= 1'b0;
    end else if (state_nxt == ST_HOLD) begin
      decrypt_en <= 1'b0;
      direct_run <= 1'b0;
      multi_step <= 1'b0;
    end else if (state_r == ST_BOOT && image_loaded) begin
      decrypt_en <= image_encrypted;
      direct_run <= image_valid;
      multi_step <= !image_valid;
    end
  end

endmodule

// [dv/rbm_boot_monitor.sv]
// Checker for the boot controller top ports.
// Assumes it is bound to rbm_boot_ctrl and sees its ports only.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module rbm_boot_monitor (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Reset sources.
  input wire ext_reset_low,
  input wire bod_core_ok,
  input wire bod_io_ok,
  // Watched outputs.
  input wire sys_reset,
  input wire osc_enable,
  input wire pll_enable,
  input wire pll_bypass,
  input wire amp_shutdown,
  input wire [3:0] boot_code,
  input wire [`RBM_SRC_W-1:0] boot_src,
  input wire boot_reserved,
  input wire boot_start,
  input wire [6:0] i2c_slave_addr,
  input wire gen_pin_one_is_clk,
  input wire gen_pin_zero_is_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Helper logic.
  // ****************************************************************
  // Cycles held with every source quiet; saturates so it never wraps.
  reg [11:0] quiet_r;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_r <= 12'h000;
    end else if (!sys_reset || !ext_reset_low || !(bod_core_ok && bod_io_ok)) begin
      quiet_r <= 12'h000;
    end else if (quiet_r != 12'hfff) begin
      quiet_r <= quiet_r + 12'h001;
    end
  end
  // Release of the internal reset.
  sequence s_release;
    $fell(sys_reset);
  endsequence
  // Launch pulse, one cycle wide.
  sequence s_launch;
    boot_start ##1 !boot_start;
  endsequence

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  chk_ext_hold:
    assert property (!ext_reset_low |=> sys_reset) else $error("External reset did not hold.");
  chk_bod_hold:
    assert property (!(bod_core_ok && bod_io_ok) |=> sys_reset && amp_shutdown) else $error("Droop not held.");
  chk_osc_on:
    assert property (osc_enable) else $error("Oscillator stopped.");
  chk_pll_off:
    assert property (sys_reset |-> !pll_enable && pll_bypass) else $error("PLL active in reset.");
  chk_code_hold:
    assert property (!sys_reset && !$past(sys_reset) |-> $stable(boot_code)) else $error("Code moved.");
  chk_rel_delay:
    assert property (s_release |-> quiet_r >= 12'h3e8) else $error("Reset released early.");
  chk_start_rel:
    assert property (boot_start |-> $fell(sys_reset) && !boot_reserved) else $error("Bad launch.");
  chk_start_pulse:
    assert property (boot_start |-> s_launch) else $error("Launch not one cycle.");
  chk_rsvd_none:
    assert property (boot_reserved |-> boot_src == 8'h00 && !boot_start) else $error("Reserved code booted.");
  chk_addr_slave:
    assert property (!sys_reset && boot_code == 4'h0 |-> i2c_slave_addr == 7'h58 && boot_src[0])
    else $error("Slave address wrong.");
  chk_fail_pins:
    assert property (!sys_reset && boot_code == 4'hf |-> gen_pin_one_is_clk && gen_pin_zero_is_data)
    else $error("Failsafe pins wrong.");
endmodule

bind rbm_boot_ctrl rbm_boot_monitor mon (.sys_clk, .rst, .ext_reset_low, .bod_core_ok, .bod_io_ok,
  .sys_reset, .osc_enable, .pll_enable, .pll_bypass, .amp_shutdown, .boot_code, .boot_src,
  .boot_reserved, .boot_start, .i2c_slave_addr, .gen_pin_one_is_clk, .gen_pin_zero_is_data);

// [dv/rbm_img_model.sv]
// Boot storage and PLL model at the far side of the loader.
// Assumes the bench sets the next image before the launch pulse.
`timescale 1ns/10ps

module rbm_img_model (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Device side.
  input wire boot_start,
  input wire pll_enable,
  // Next image and its load latency.
  input wire want_valid,
  input wire want_enc,
  input wire [3:0] lat,
  // Answers.
  output reg image_loaded,
  output reg image_valid,
  output reg image_encrypted,
  output reg pll_locked,
  output reg pll_cfg_done
);
  reg [3:0] cnt_r; // Cycles left in the load.
  reg busy_r; // A load is running.
  // Image valid and encrypted flags show the wrong value outside the load pulse on purpose.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {image_loaded, image_valid, image_encrypted, pll_locked, pll_cfg_done, busy_r} <= 6'h00;
      cnt_r <= 4'h0;
    end else begin
      image_loaded <= 1'b0;
      image_valid <= ~want_valid;
      image_encrypted <= ~want_enc;
      pll_locked <= pll_enable;
      pll_cfg_done <= pll_enable & pll_locked;
      if (boot_start) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        image_loaded <= 1'b1;
        image_valid <= want_valid;
        image_encrypted <= want_enc;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// [dv/tb_rbm_boot_ctrl.sv]
// Self-checking bench for the reset sequencer and strap latch.
// Assumes the image model answers each launch within sixteen cycles.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module tb_rbm_boot_ctrl;
  reg sys_clk, rst, ext_reset_low, bod_core_ok, bod_io_ok, want_valid, want_enc;
  reg [3:0] straps, lat;
  integer error_cnt, tests_run, k, seed;
  wire pll_locked, pll_cfg_done, image_valid, image_loaded, image_encrypted;
  wire sys_reset, osc_enable, pll_enable, pll_bypass, amp_shutdown, boot_reserved, boot_start;
  wire gen_pin_one_is_clk, gen_pin_zero_is_data, async_serial_if_en, decrypt_en, direct_run, multi_step;
  wire [3:0] boot_code;
  wire [7:0] boot_src;
  wire [23:0] boot_rate;
  wire [6:0] i2c_slave_addr;

  rbm_boot_ctrl uut (.sys_clk, .rst, .ext_reset_low, .bod_core_ok, .bod_io_ok,
    .boot_strap_3(straps[3]), .boot_strap_2(straps[2]), .boot_strap_1(straps[1]), .boot_strap_0(straps[0]),
    .pll_locked, .pll_cfg_done, .image_valid, .image_loaded, .image_encrypted, .sys_reset, .osc_enable,
    .pll_enable, .pll_bypass, .amp_shutdown, .boot_code, .boot_src, .boot_rate, .boot_reserved, .boot_start,
    .i2c_slave_addr, .gen_pin_one_is_clk, .gen_pin_zero_is_data, .async_serial_if_en, .decrypt_en,
    .direct_run, .multi_step);
  rbm_img_model img (.sys_clk, .rst, .boot_start, .pll_enable, .want_valid, .want_enc, .lat,
    .image_loaded, .image_valid, .image_encrypted, .pll_locked, .pll_cfg_done);

  // Reference table: boot rate above the one-hot source set.
  function [31:0] exp_mode(input [3:0] c);
    begin
      case (c)
        4'h0: exp_mode = {`RBM_RATE_EXT, 8'h01};
        4'h1: exp_mode = {`RBM_RATE_400K, 8'h86};
        4'h2: exp_mode = {`RBM_RATE_1M53, 8'h86};
        4'h3: exp_mode = {`RBM_RATE_EXT, 8'h08};
        4'h7: exp_mode = {`RBM_RATE_384K, 8'h10};
        4'hb: exp_mode = {`RBM_RATE_9600, 8'h10};
        4'hc: exp_mode = {`RBM_RATE_1M53, 8'ha4};
        4'hd: exp_mode = {`RBM_RATE_400K, 8'ha4};
        4'he: exp_mode = {`RBM_RATE_EXT, 8'ha0};
        4'hf: exp_mode = {`RBM_RATE_400K, 8'hc0};
        default: exp_mode = 32'h00000000;
      endcase
    end
  endfunction

  task chk(input string name, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, e, g);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (error_cnt == 0 && tests_run > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  // One full reset and latch for a strap code, then launch and load unless the code is reserved.
  task run_code(input [3:0] c);
    integer i;
    reg [31:0] m;
    reg [31:0] r;
    begin
      m = exp_mode(c);
      r = $urandom;
      @(negedge sys_clk);
      ext_reset_low = 1'b0;
      straps = c;
      {lat, want_enc, want_valid} = r[5:0];
      @(negedge sys_clk);
      chk("reset state", 32'h000000d8, {24'h000000, sys_reset, osc_enable, pll_enable, pll_bypass,
        amp_shutdown, boot_start, direct_run, multi_step});
      ext_reset_low = 1'b1;
      @(negedge sys_clk);
      straps = ~c;
      i = 0;
      while (boot_start !== 1'b1 && i < 1100) begin
        @(negedge sys_clk);
        i = i + 1;
      end
      chk("launch wait", (m[7:0] == 8'h00) ? 1100 : `RBM_REL_CYCLES, i);
      if (i == 1100 && m[7:0] != 8'h00) report_and_stop;
      chk("mode", m, {boot_rate, boot_src});
      chk("pins", {17'h00000, m[7:0] == 8'h00, (c == 4'h0) ? 7'h58 : 7'h00, c == 4'hf, c == 4'hf,
        c == 4'h7 || c == 4'hb, c}, {17'h00000, boot_reserved, i2c_slave_addr, gen_pin_one_is_clk,
        gen_pin_zero_is_data, async_serial_if_en, boot_code});
      if (m[7:0] != 8'h00) begin
        i = 0;
        while (pll_bypass !== 1'b0 && i < 40) begin
          @(negedge sys_clk);
          i = i + 1;
        end
        chk("outcome", {29'h00000000, want_valid, !want_valid, want_enc},
          {29'h00000000, direct_run, multi_step, decrypt_en});
        chk("run state", 32'h00000001, {29'h00000000, amp_shutdown, pll_bypass, pll_enable});
        if (i == 40) report_and_stop;
      end
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Every strap code, then a droop on each supply while running.
  initial begin
    {rst, ext_reset_low, bod_core_ok, bod_io_ok, want_valid, want_enc} = 6'h3c;
    straps = 4'h0;
    lat = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    seed = $urandom(48);
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    for (k = 0; k < 16; k = k + 1) begin
      run_code(k[3:0]);
    end
    for (k = 0; k < 2; k = k + 1) begin
      run_code(4'hf);
      {bod_core_ok, bod_io_ok} = k[0] ? 2'h1 : 2'h2;
      @(negedge sys_clk);
      chk("droop", 32'h00000003, {30'h00000000, sys_reset, amp_shutdown});
      {bod_core_ok, bod_io_ok} = 2'h3;
    end
    report_and_stop;
  end
endmodule
